// File: hw/supply_monitor_pkg.sv
// Constants shared by the supply monitor and its synchroniser
package supply_monitor_pkg;
  localparam logic [15:0] ctrl_addr         = 16'hff50;
  localparam logic [15:0] level_addr        = 16'hff51;
  localparam logic [15:0] cause_addr        = 16'hff54;
  localparam logic [7:0]  ctrl_reset        = 8'h00;
  localparam logic [7:0]  level_reset       = 8'h00;
  localparam logic [7:0]  cause_reset       = 8'h00;
  localparam int          enable_bit        = 7;
  localparam int          action_bit        = 1;
  localparam int          flag_bit          = 0;
  localparam int          det_cause_bit     = 0;
  localparam int          wdt_cause_bit     = 4;
  localparam logic [3:0]  level_code_max    = 4'h9;
  localparam int          sync_stages       = 2;
  // Source of the most recent reset
  typedef enum logic [1:0] {
    cause_power = 2'b00,
    cause_pin   = 2'b01,
    cause_det   = 2'b11,
    cause_wdt   = 2'b10
  } reset_src_t;
endpackage

// File: hw/level_sync.sv
// Two-stage synchroniser for asynchronous comparator levels
`timescale 1ns/100ps
module level_sync (
  input  wire logic       clk,     // System clock
  input  wire logic       arst_n,  // Asynchronous reset, active low
  input  wire logic [1:0] din,     // Asynchronous levels
  output logic      [1:0] dout     // Synchronised levels
);
  import supply_monitor_pkg::*;
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
  } sync_state_t;
  sync_state_t st, next_st;

  always_comb begin
    next_st        = st;
    next_st.meta   = din;
    next_st.stable = st.meta;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.stable;
endmodule // level_sync

// File: hw/supply_monitor_reset_irq.sv
// Power-on comparator reset and programmable low-voltage detector
// Function
// - Hold internal reset while supply below threshold
// - Detector reset sets detector cause bit 0
// - Control at ff50, resets 00, bits 2-6 zero
// - Control bit 7 enables detection
// - Control bit 1: interrupt or reset
// - Bit 0 shows supply low while enabled
// - Flag bit is read-only
// - Detector reset keeps control; others clear it
// - Enable starts comparator feeding flag
// - Irq follows flag when enabled, interrupt mode
// - Level at ff51, byte-written, kept on detector reset
// - Codes 0 to 9 select ten levels
// - Cause register clears on pin, power, read
// - Detector and watchdog resets each hold the other's flag
// - Reset mode alone never forces reset
`timescale 1ns/100ps
module supply_monitor_reset_irq (
  input  wire logic        clk,             // System clock, 250 MHz
  input  wire logic        arst_n,          // Power rail reset, active low
  input  wire logic        pin_reset_n,     // Sync external pin reset, low
  input  wire logic        wdt_reset_req,   // Watchdog reset request
  input  wire logic        por_below,       // Power-on comparator: low
  input  wire logic        det_below,       // Detector comparator: low
  output logic             det_comp_on,     // Powers detector comparator
  output logic [3:0]       level_code,      // Threshold code to analog
  input  wire logic [15:0] addr,            // Register byte address
  input  wire logic        wr_byte,         // Whole-byte write strobe
  input  wire logic        wr_bit,          // Single-bit write strobe
  input  wire logic [2:0]  bit_sel,         // Bit index for bit write
  input  wire logic [7:0]  wdata,           // Write data
  input  wire logic        rd,              // Read strobe
  output logic      [7:0]  rdata,           // Read data, registered
  output logic             supply_low_irq,  // Detector interrupt request
  output logic             internal_reset   // Chip reset, active high
);
  import supply_monitor_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic       enable;
    logic       action;
    logic [3:0] level;
    logic       wdt_cause;
    logic       det_cause;
    logic       det_reset;
    logic       wdt_reset;
    logic [7:0] rdata;
  } mon_state_t;
  mon_state_t st, next_st;
  logic [1:0] sync_out;
  logic       por_low;
  logic       det_low;
  logic       flag;

  // Levels from analog side never reach logic unsynchronised
  level_sync u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    ({por_below, det_below}),
    .dout   (sync_out)
  );
  assign por_low = sync_out[1];
  assign det_low = sync_out[0];

  function automatic logic [7:0] ctrl_view(input mon_state_t s,
                                           input logic f);
    ctrl_view                = 8'h00;
    ctrl_view[enable_bit]    = s.enable;
    ctrl_view[action_bit]    = s.action;
    ctrl_view[flag_bit]      = f;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  assign flag           = st.enable & det_low;
  assign det_comp_on    = st.enable;
  assign level_code     = st.level;
  assign supply_low_irq = flag & ~st.action;
  // Power rail low overrides everything; reset lasts while cause stands
  assign internal_reset = por_low | st.det_reset
                        | st.wdt_reset | ~pin_reset_n;
  assign rdata          = st.rdata;

  always_comb begin
    logic [7:0] cv;
    cv      = ctrl_view(st, flag);
    next_st = st;
    next_st.rdata = 8'h00;
    if (rd) begin
      case (addr)
        ctrl_addr:  next_st.rdata = cv;
        level_addr: next_st.rdata = {4'h0, st.level};
        cause_addr: begin
          next_st.rdata[wdt_cause_bit] = st.wdt_cause;
          next_st.rdata[det_cause_bit] = st.det_cause;
          next_st.wdt_cause = 1'b0;
          next_st.det_cause = 1'b0;
        end
        default:    next_st.rdata = 8'h00;
      endcase
    end
    if (wr_byte && addr == ctrl_addr) begin
      next_st.enable = wdata[enable_bit];
      next_st.action = wdata[action_bit];
    end
    if (wr_bit && addr == ctrl_addr) begin
      if (bit_sel == 3'(enable_bit)) next_st.enable = wdata[0];
      if (bit_sel == 3'(action_bit)) next_st.action = wdata[0];
    end
    // Undefined mid-operation; we simply take the byte
    if (wr_byte && addr == level_addr) begin
      next_st.level = wdata[3:0];
    end
    // Reset mode only acts on low supply, never on the mode write
    next_st.det_reset = flag & st.action;
    next_st.wdt_reset = wdt_reset_req;
    // Set wins over the read clear
    if (st.det_reset) next_st.det_cause = 1'b1;
    if (st.wdt_reset) next_st.wdt_cause = 1'b1;
    // Pin and power resets clear everything; detector reset keeps it
    if (por_low || !pin_reset_n) begin
      next_st = '0;
    end else if (st.wdt_reset) begin
      next_st.enable    = 1'b0;
      next_st.action    = 1'b0;
      next_st.level     = level_reset[3:0];
      next_st.det_reset = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  property p_irq_follows;
    @(posedge clk) disable iff (!arst_n)
      (st.enable && !st.action) |-> (supply_low_irq == det_low);
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("irq does not follow flag");

  property p_por_reset;
    @(posedge clk) disable iff (!arst_n)
      por_low |-> internal_reset ##1 (!st.enable && !st.action);
  endproperty
  a_por_reset: assert property (p_por_reset)
    else $error("power low did not reset");

  property p_det_cause;
    @(posedge clk) disable iff (!arst_n)
      (st.det_reset && !por_low && pin_reset_n) |=> st.det_cause;
  endproperty
  a_det_cause: assert property (p_det_cause)
    else $error("detector cause not set");

  property p_det_keeps;
    @(posedge clk) disable iff (!arst_n)
      (st.det_reset && !st.wdt_reset && !por_low && pin_reset_n
       && !wr_byte && !wr_bit) |=> $stable(st.level) && st.enable;
  endproperty
  a_det_keeps: assert property (p_det_keeps)
    else $error("detector reset changed control");

  property p_flag_off;
    @(posedge clk) disable iff (!arst_n)
      !st.enable |-> !supply_low_irq && !st.det_reset ##1 !st.det_reset;
  endproperty
  a_flag_off: assert property (p_flag_off)
    else $error("disabled detector acted");

  property p_mode_no_reset;
    @(posedge clk) disable iff (!arst_n)
      !det_low |=> !st.det_reset;
  endproperty
  a_mode_no_reset: assert property (p_mode_no_reset)
    else $error("reset without low supply");

  property p_ctrl_read;
    @(posedge clk) disable iff (!arst_n)
      (rd && addr == ctrl_addr) |=> (rdata[6:2] == 5'h00)
        && rdata[enable_bit] == $past(st.enable);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control read wrong");

  property p_cause_clear;
    @(posedge clk) disable iff (!arst_n)
      (rd && addr == cause_addr && !st.det_reset && !st.wdt_reset)
        |=> !st.det_cause && !st.wdt_cause;
  endproperty
  a_cause_clear: assert property (p_cause_clear)
    else $error("cause not cleared by read");

  property p_level_write;
    @(posedge clk) disable iff (!arst_n)
      (wr_byte && addr == level_addr && !por_low && pin_reset_n
       && !st.wdt_reset) |=> level_code == $past(wdata[3:0]);
  endproperty
  a_level_write: assert property (p_level_write)
    else $error("level write lost");

  c_irq:       cover property (@(posedge clk) supply_low_irq);
  c_det_reset: cover property (@(posedge clk) st.det_reset);
  c_wdt_reset: cover property (@(posedge clk) st.wdt_reset);
  c_cause_rd:  cover property (@(posedge clk)
                 rd && addr == cause_addr && st.det_cause);
endmodule // supply_monitor_reset_irq

// File: verif/supply_comparators.sv
// Behavioural model of the two analog supply comparators
`timescale 1ns/100ps
module supply_comparators (
  input  wire logic [12:0] supply_mv,  // Supply, millivolts
  input  wire logic        comp_on,    // Detector comparator powered
  input  wire logic [3:0]  code,       // Selected level code
  output logic             por_low,    // Below power-on threshold
  output logic             det_low     // Below selected threshold
);
  localparam logic [12:0] thr [10] = '{13'h10cc, 13'h1004, 13'h0f3c,
    13'h0e74, 13'h0dac, 13'h0ce4, 13'h0c1c, 13'h0b22, 13'h0a28, 13'h092e};
  assign por_low = supply_mv < 13'h0834;
  // Prohibited codes leave the detector silent
  assign det_low = comp_on && code <= 4'h9
                   && supply_mv < thr[code];
endmodule // supply_comparators

// File: verif/tb.sv
// Self-checking bench for the supply monitor
`timescale 1ns/100ps
module tb;
  import supply_monitor_pkg::*;
  localparam logic [12:0] lvl [10] = '{13'h10cc, 13'h1004, 13'h0f3c,
    13'h0e74, 13'h0dac, 13'h0ce4, 13'h0c1c, 13'h0b22, 13'h0a28, 13'h092e};
  logic        clk, arst_n, pin_reset_n, wdt_reset_req, exp;
  logic        por_below, det_below, det_comp_on, supply_low_irq;
  logic        wr_byte, wr_bit, rd, internal_reset;
  logic [3:0]  level_code, code;
  logic [15:0] addr;
  logic [2:0]  bit_sel;
  logic [7:0]  wdata, rdata, rv;
  logic [12:0] supply_mv;
  int          mismatches, samples_checked;

  supply_monitor_reset_irq uut (.clk(clk), .arst_n(arst_n),
    .pin_reset_n(pin_reset_n), .wdt_reset_req(wdt_reset_req),
    .por_below(por_below), .det_below(det_below),
    .det_comp_on(det_comp_on), .level_code(level_code), .addr(addr),
    .wr_byte(wr_byte), .wr_bit(wr_bit), .bit_sel(bit_sel),
    .wdata(wdata), .rd(rd), .rdata(rdata),
    .supply_low_irq(supply_low_irq), .internal_reset(internal_reset));
  supply_comparators far (.supply_mv(supply_mv), .comp_on(det_comp_on),
    .code(level_code), .por_low(por_below), .det_low(det_below));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////
  task automatic check(input string n, input logic [7:0] seen,
                       input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, want, seen);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Inputs move 1 ns after the edge, clear of sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cyc(1);
    addr = a;
    wdata = d;
    wr_byte = 1'b1;
    cyc(1);
    wr_byte = 1'b0;
  endtask
  task automatic wbit(input logic [2:0] b, input logic v);
    cyc(1);
    addr = ctrl_addr;
    bit_sel = b;
    wdata = {7'h00, v};
    wr_bit = 1'b1;
    cyc(1);
    wr_bit = 1'b0;
  endtask
  task automatic ckreg(input string n, input logic [15:0] a,
                       input logic [7:0] want);
    cyc(1);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    check(n, rdata, want);
  endtask
  task automatic wait_rst(input logic want);
    for (int i = 0; i < 10 && internal_reset !== want; i++) cyc(1);
    check("internal_reset", {7'h00, internal_reset}, {7'h00, want});
    if (internal_reset !== want) conclude();
  endtask
  task automatic pulse_wdt();
    cyc(1);
    wdt_reset_req = 1'b1;
    cyc(1);
    wdt_reset_req = 1'b0;
    cyc(4);
  endtask

  ////////////////////////////////////////
  initial begin
    {arst_n, wr_byte, wr_bit, rd, wdt_reset_req} = 5'h00;
    {pin_reset_n, addr, wdata, bit_sel} = {1'b1, 27'h0000000};
    supply_mv = 13'h1388;
    mismatches = 0;
    samples_checked = 0;
    void'($urandom(32'h0a0857be));
    cyc(5);
    arst_n = 1'b1;
    ckreg("control", ctrl_addr, ctrl_reset);
    ckreg("level", level_addr, level_reset);
    ckreg("unmapped", 16'hff52, 8'h00);
    // Reserved bits stay zero; the read-only flag bit is still poked
    wr(ctrl_addr, 8'h83);
    cyc(4);
    ckreg("control", ctrl_addr, 8'h82);
    check("rst", {7'h00, internal_reset}, 8'h00);
    wbit(3'd0, 1'b1);
    ckreg("control", ctrl_addr, 8'h82);
    wbit(3'd1, 1'b0);
    wbit(3'd7, 1'b0);
    ckreg("control", ctrl_addr, 8'h00);
    $display("Test registers done");
    for (int i = 0; i < 16; i++) begin
      code = (i < 10) ? 4'(i) : 4'($urandom_range(9));
      wr(ctrl_addr, 8'h00);
      wr(level_addr, {4'h0, code});
      wr(ctrl_addr, 8'h80);
      supply_mv = i[0] ? lvl[code] - 13'h00c8 + 13'($urandom_range(400))
                       : lvl[code];
      // Model comparator settles at once, so the start-up wait is short
      cyc(4);
      exp = supply_mv < lvl[code];
      check("level_code", {4'h0, level_code}, {4'h0, code});
      ckreg("flag", ctrl_addr, {7'h40, exp});
      check("irq", {7'h00, supply_low_irq}, {7'h00, exp});
      check("comp_on", {7'h00, det_comp_on}, 8'h01);
    end
    $display("Test levels done");
    wr(ctrl_addr, 8'h00);
    supply_mv = 13'h0898;
    cyc(4);
    ckreg("flag", ctrl_addr, 8'h00);
    supply_mv = 13'h1388;
    wr(level_addr, 8'h05);
    wr(ctrl_addr, 8'h80);
    wbit(3'd1, 1'b1);
    cyc(4);
    check("rst", {7'h00, internal_reset}, 8'h00);
    for (int k = 0; k < 2; k++) begin
      supply_mv = 13'h0ce3;
      wait_rst(1'b1);
      supply_mv = 13'h1388;
      cyc(4);
    end
    ckreg("cause", cause_addr, 8'h01);
    ckreg("control", ctrl_addr, 8'h82);
    ckreg("level", level_addr, 8'h05);
    ckreg("cause", cause_addr, 8'h00);
    wait_rst(1'b0);
    supply_mv = 13'h0ce3;
    wait_rst(1'b1);
    supply_mv = 13'h1388;
    cyc(4);
    pulse_wdt();
    ckreg("cause", cause_addr, 8'h11);
    ckreg("control", ctrl_addr, 8'h00);
    ckreg("level", level_addr, 8'h00);
    $display("Test detector reset done");
    pulse_wdt();
    wr(level_addr, 8'h07);
    pin_reset_n = 1'b0;
    wait_rst(1'b1);
    // Pin must be seen low on clock edges, or nothing is cleared
    cyc(2);
    pin_reset_n = 1'b1;
    cyc(4);
    ckreg("cause", cause_addr, 8'h00);
    ckreg("level", level_addr, 8'h00);
    wr(level_addr, 8'h03);
    supply_mv = 13'h0834;
    cyc(4);
    check("rst", {7'h00, internal_reset}, 8'h00);
    supply_mv = 13'h0833;
    wait_rst(1'b1);
    supply_mv = 13'h1388;
    wait_rst(1'b0);
    ckreg("level", level_addr, 8'h00);
    $display("Test power-on done");
    conclude();
  end
endmodule // tb
